// >>> tcc_regs.svh
// Register offsets, fields, reset values and edge counts of the timer capture control block
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_CTRL_OFFSET 8'h16
`define TCC_CTRL_BANK 3'h3
`define TCC_CTRL_BYTE_ADDR 12'h358
`define TCC_CTRL_RESET 8'h00
`define TCC_CAP2_MODE_LSB 6
`define TCC_CAP1_MODE_LSB 4
`define TCC_CONCAT_BIT 3
`define TCC_T3_CS_BIT 2
`define TCC_T2_CS_BIT 1
`define TCC_T1_CS_BIT 0
`define TCC_PRESCALE_4 5'h04
`define TCC_PRESCALE_16 5'h10
`endif

// >>> tcc_pkg.sv
// Types shared by the timer capture control block
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_EDGE_FALL,
        TCC_EDGE_RISE,
        TCC_EDGE_RISE4,
        TCC_EDGE_RISE16
    } tcc_edge_mode_type;

    typedef struct packed {
        logic [1:0] cap2_edge_mode;
        logic [1:0] cap1_edge_mode;
        logic timer_pair_concat;
        logic timer3_clk_select;
        logic timer2_clk_select;
        logic timer1_clk_select;
    } tcc_ctrl_type;

    typedef struct packed {
        logic timer_one_inc;
        logic timer_two_inc;
        logic timer_three_inc;
        logic timer_pair_concat;
    } tcc_timer_ctl_type;
endpackage : tcc_pkg

// >>> tcc_top.sv
// Timer capture control register with AXI4-Lite access, capture edge and timer increment logic
`timescale 1ns/1ps
`include "tcc_regs.svh"
// The block holds the control byte and turns it into capture strobes and timer
// increment strobes; the capture registers and the timers themselves live outside.
// clk_en low freezes every flop, the bus included.
module tcc_top #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cap1_pin,
    input wire logic cap2_pin,
    input wire logic timer12_ext_clk_pin,
    input wire logic timer3_ext_clk_pin,
    input wire logic internal_tick,
    output logic [1:0] cap_trigger,
    output tcc_pkg::tcc_timer_ctl_type timer_ctl,
    output tcc_pkg::tcc_ctrl_type ctrl_out
);
    // Software view of the control byte
    tcc_pkg::tcc_ctrl_type ctrl_reg;

    // Write halves parked until both have arrived
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg;
    logic aw_have_reg;
    logic w_have_reg;

    // Previous pin samples for edge detection
    logic [1:0] pin_prev_reg;
    logic tclk12_prev_reg;
    logic tclk3_prev_reg;

    // Rising-edge prescale counter per capture channel
    logic [4:0] edge_cnt_reg [2];

    // Address or data is held until both halves are present
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_ok = aw_have_reg || aw_take;
    wire w_ok = w_have_reg || w_take;
    wire [ADDR_W-1:0] wr_addr = aw_have_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_have_reg ? wdata_reg : s_axi_wdata;
    wire wr_strb0 = w_have_reg ? wstrb0_reg : s_axi_wstrb[0];
    wire wr_fire = aw_ok && w_ok && !s_axi_bvalid;
    wire wr_hit = wr_addr == ADDR_W'(`TCC_CTRL_BYTE_ADDR);
    // Unmapped words answer SLVERR; a clear byte-0 strobe still answers OKAY
    wire [1:0] wr_resp = wr_hit ? 2'h0 : 2'h2;
    wire wr_load = wr_fire && wr_hit && wr_strb0;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire rd_hit = s_axi_araddr == ADDR_W'(`TCC_CTRL_BYTE_ADDR);
    // Reads of unmapped words return zero so no stale data leaks out
    wire [31:0] rd_word = rd_hit ? {24'h00_0000, ctrl_reg} : 32'h0000_0000;
    wire [1:0] rd_resp = rd_hit ? 2'h0 : 2'h2;
    wire [1:0] cap_pins = {cap2_pin, cap1_pin};
    wire [1:0] cap_mode [2];
    // Falling edges of the timer pins are found against the previous sample
    wire t12_fall = tclk12_prev_reg && !timer12_ext_clk_pin;
    wire t3_fall = tclk3_prev_reg && !timer3_ext_clk_pin;
    // Timers one and two share a pin, yet each keeps its own source select
    wire t1_inc = ctrl_reg.timer1_clk_select ? t12_fall : internal_tick;
    wire t2_inc = ctrl_reg.timer2_clk_select ? t12_fall : internal_tick;
    wire t3_inc = ctrl_reg.timer3_clk_select ? t3_fall : internal_tick;

    // Channel index 0 is capture one, index 1 capture two
    assign cap_mode[0] = ctrl_reg.cap1_edge_mode;
    assign cap_mode[1] = ctrl_reg.cap2_edge_mode;

    // Write channel: either half may arrive first and is parked until its partner comes.
    // The response is raised on the edge that completes the pair, so at most one write
    // is under way; both readies stay low until the response has been accepted.

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_ok && !s_axi_bvalid;
            s_axi_wready <= !w_ok && !s_axi_bvalid;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            aw_have_reg <= aw_ok && !wr_fire;
            w_have_reg <= w_ok && !wr_fire;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_resp;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                // Readies come back one cycle after the response is taken
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Only byte lane 0 carries the register; the other lanes are ignored
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_reg <= `TCC_CTRL_RESET;
        end else if (clk_en && wr_load) begin
            ctrl_reg <= wr_data[7:0];
        end
    end

    // Read channel: one read at a time; arready stays low while a result waits,
    // so the address needs no parking register

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_resp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pins are taken as already synchronous to clk_sys; a pin from another clock
    // domain needs a synchroniser in front of this block
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_prev_reg <= 2'h0;
            tclk12_prev_reg <= 1'b0;
            tclk3_prev_reg <= 1'b0;
        end else if (clk_en) begin
            pin_prev_reg <= cap_pins;
            tclk12_prev_reg <= timer12_ext_clk_pin;
            tclk3_prev_reg <= timer3_ext_clk_pin;
        end
    end

    // Increment strobes and the pairing flag leave through flops; the timers sit outside.
    // The pairing flag only steers those timers, nothing here depends on it.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            timer_ctl <= '0;
            ctrl_out <= '0;
        end else if (clk_en) begin
            timer_ctl.timer_one_inc <= t1_inc;
            timer_ctl.timer_two_inc <= t2_inc;
            timer_ctl.timer_three_inc <= t3_inc;
            timer_ctl.timer_pair_concat <= ctrl_reg.timer_pair_concat;
            ctrl_out <= ctrl_reg;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_cap
            // Mode decode per channel; one counter serves both prescaled modes
            wire mode_fall = cap_mode[ch] == 2'(tcc_pkg::TCC_EDGE_FALL);
            wire mode_rise = cap_mode[ch] == 2'(tcc_pkg::TCC_EDGE_RISE);
            wire mode_rise4 = cap_mode[ch] == 2'(tcc_pkg::TCC_EDGE_RISE4);
            wire prescaled = cap_mode[ch][1];
            wire rise = !pin_prev_reg[ch] && cap_pins[ch];
            wire fall = pin_prev_reg[ch] && !cap_pins[ch];
            // Switching between 4 and 16 keeps the count; a count already past the new
            // limit fires on the next rising edge rather than wrapping round
            wire [4:0] limit = mode_rise4 ? `TCC_PRESCALE_4 : `TCC_PRESCALE_16;
            wire [4:0] cnt_inc = edge_cnt_reg[ch] + 5'h01;
            wire hit = cnt_inc >= limit;
            wire fire_fall = mode_fall && fall;
            wire fire_rise = mode_rise && rise;
            wire fire_scaled = prescaled && rise && hit;
            wire fire = fire_fall || fire_rise || fire_scaled;
            wire [4:0] cnt_hold = rise ? (hit ? 5'h00 : cnt_inc) : edge_cnt_reg[ch];
            wire [4:0] cnt_next = prescaled ? cnt_hold : 5'h00;

            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    cap_trigger[ch] <= 1'b0;
                end else if (clk_en) begin
                    cap_trigger[ch] <= fire;
                end
            end

            // Count is cleared outside the prescaled modes so a later switch starts fresh
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    edge_cnt_reg[ch] <= 5'h00;
                end else if (clk_en) begin
                    edge_cnt_reg[ch] <= cnt_next;
                end
            end
        end
    endgenerate
endmodule : tcc_top

// >>> tcc_properties.sv
// Port checker of the timer capture control block
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_properties #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys, rst_b, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic cap1_pin, cap2_pin, timer12_ext_clk_pin, internal_tick,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic [1:0] cap_trigger,
    input wire tcc_pkg::tcc_timer_ctl_type timer_ctl,
    input wire tcc_pkg::tcc_ctrl_type ctrl_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b || !clk_en);
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_resp: assert property (s_wr |=> s_axi_bvalid)
        else $error("no write answer");
    a_ctrl_load: assert property (
        s_wr ##0 (s_axi_awaddr == `TCC_CTRL_BYTE_ADDR && s_axi_wstrb[0])
        |=> ##1 ctrl_out == $past(s_axi_wdata[7:0], 2)) else $error("byte not loaded");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_rise_cap: assert property (
        ctrl_out[5:4] == 2'h1 && $stable(ctrl_out) && $rose(cap1_pin) |=> cap_trigger[0]) else $error("rise missed");
    a_fall_cap: assert property (
        ctrl_out[7:6] == 2'h0 && $stable(ctrl_out) && $fell(cap2_pin) |=> cap_trigger[1]) else $error("fall missed");
    a_ext_tick: assert property (
        ctrl_out[0] && $stable(ctrl_out) && $fell(timer12_ext_clk_pin) |=> timer_ctl[3]) else $error("pin tick missed");
    a_int_tick: assert property (
        !ctrl_out[1] && $stable(ctrl_out) && internal_tick |=> timer_ctl[2]) else $error("tick missed");
    a_concat_flag: assert property ($stable(ctrl_out) |-> timer_ctl[0] == ctrl_out[3])
        else $error("concat wrong");
endmodule : tcc_properties
bind tcc_top tcc_properties #(.ADDR_W(ADDR_W)) u_props (.*);

// >>> tcc_pin_model.sv
// Far-side pin model: capture and timer clock pins
`timescale 1ns/1ps
module tcc_pin_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic run,
    output logic [3:0] pins
);
    // Pins toggle together each edge while run is high, so every pin sees a rise then a fall
    always @(posedge clk_sys) begin
        if (!rst_b)
            pins <= 4'h0;
        else if (run)
            pins <= ~pins;
    end
endmodule : tcc_pin_model

// >>> testbench.sv
// Self-checking bench of the timer capture control block
`timescale 1ns/1ps
`include "tcc_regs.svh"
module testbench;
    localparam logic [11:0] A = `TCC_CTRL_BYTE_ADDR;
    logic clk_sys = 1'h0, rst_b = 1'h0, clk_en = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, internal_tick = 1'h0, run = 1'h0, tk;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cap1_pin, cap2_pin, timer12_ext_clk_pin, timer3_ext_clk_pin;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q[$];
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, cap_trigger, qr[$];
    logic [7:0] c;
    tcc_pkg::tcc_timer_ctl_type timer_ctl;
    tcc_pkg::tcc_ctrl_type ctrl_out;
    int fails, n_tests, cyc, nt, cnt[5], base[5], seed = 32'h09fccb4c;
    wire logic [4:0] hits = {timer_ctl[3:1], cap_trigger};
    tcc_top dut (.*);
    tcc_pin_model far (.clk_sys, .rst_b, .run, .pins({timer3_ext_clk_pin, timer12_ext_clk_pin, cap2_pin, cap1_pin}));
    always #2.5 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        q.push_back(32'(r));
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, s, 3'h7};
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        qr.push_back(a == A ? 2'h0 : 2'h2);
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask : rd
    // Results are matched in arrival order; bus accesses never overlap
    always @(posedge clk_sys) begin
        cyc++;
        foreach (cnt[i]) cnt[i] += hits[i];
        if (s_axi_bvalid && s_axi_bready) check(32'(s_axi_bresp), q.pop_front());
        if (s_axi_rvalid && s_axi_rready) check(s_axi_rdata, q.pop_front());
        if (s_axi_rvalid && s_axi_rready) check(32'(s_axi_rresp), 32'(qr.pop_front()));
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'h1;
        wr(A + 12'h4, 32'hff, 4'hf, 2'h2);
        rd(A + 12'h4, 32'h0);
        rd(A, 32'h0);
        $display("bus test done");
        for (int i = 0; i < 8; i++) begin
            c = {i[1:0], i[2:1], 4'($random(seed))};
            wr(A, 32'(c), 4'hf, 2'h0);
            wr(A, 32'(~c), 4'he, 2'h0);
            rd(A, 32'(c));
            repeat (3) @(posedge clk_sys);
            check(32'(ctrl_out), 32'(c));
            base = cnt;
            nt = 0;
            run <= 1'h1;
            repeat (64) begin
                tk = 1'($random(seed));
                internal_tick <= tk;
                nt += tk;
                @(posedge clk_sys);
            end
            run <= 1'h0;
            internal_tick <= 1'h0;
            repeat (3) @(posedge clk_sys);
            check(cnt[0] - base[0], 32 / (c[5] ? (c[4] ? `TCC_PRESCALE_16 : `TCC_PRESCALE_4) : 1));
            check(cnt[1] - base[1], 32 / (c[7] ? (c[6] ? `TCC_PRESCALE_16 : `TCC_PRESCALE_4) : 1));
            check(cnt[4] - base[4], c[0] ? 32 : nt);
            check(cnt[3] - base[3], c[1] ? 32 : nt);
            check(cnt[2] - base[2], c[2] ? 32 : nt);
            check(32'(timer_ctl[0]), 32'(c[3]));
            $display("mode test %0d done", i);
        end
        // Enable low must freeze every strobe while pins and ticks keep moving
        clk_en <= 1'h0;
        base = cnt;
        run <= 1'h1;
        internal_tick <= 1'h1;
        repeat (16) @(posedge clk_sys);
        run <= 1'h0;
        internal_tick <= 1'h0;
        clk_en <= 1'h1;
        repeat (3) @(posedge clk_sys);
        nt = 0;
        foreach (cnt[k]) nt += cnt[k] - base[k];
        check(nt, 0);
        $display("freeze test done");
        give_verdict();
    end
endmodule : testbench
